// *** rtl/pio_cmd_top.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Parallel I/O command handler
// ****************************************************************
module pio_cmd_top #(
	parameter int CYC_PER_MS = pio_pkg::CYC_PER_MS
) (
	input wire logic REF_CLK, // 10 MHz clock
	input wire logic RESET, // Async reset, high
	input wire logic [7:0] ADDR, // Register byte address
	input wire logic [31:0] WDATA, // Write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	output logic [31:0] RDATA, // Read data, cycle after RD
	input wire logic [pio_pkg::NLINES-1:0] DIO_IN, // I/O pins in
	output logic [pio_pkg::NLINES-1:0] DIO_OUT, // I/O pins out
	output logic [pio_pkg::NLINES-1:0] DIO_OE, // I/O pin drive enable
	output logic DATA_STROBE, // Data strobe pulse
	input wire logic [7:0] ADDR_SW, // Address switch pins
	input wire logic EXT_ADDR_EN, // External address enable pin
	output logic [4:0] BUS_ADDR, // Applied bus address
	output logic CMD_ERROR // Sticky error flag
);
	import pio_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Lowest set byte at or above from; bit 3 set means none
	function automatic logic [3:0] pio_next(input logic [4:0] m, input logic [3:0] from);
		logic [3:0] r;
		r = 4'h8;
		for (int i = NBYTES - 1; i >= 0; i--) begin
			if (m[i] && 4'(i) >= from) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : pio_next

	// Character to nibble; bit 4 flags a valid character
	function automatic logic [4:0] pio_dec(input logic [7:0] c, input logic [1:0] f);
		logic [4:0] r;
		r = 5'h00;
		if (f == FMT_LEG) begin
			if (c[7:4] == CH_LEG_HI) begin
				r = {1'b1, c[3:0]};
			end
		end else if (c >= CH_ZERO && c <= CH_NINE) begin
			r = {1'b1, c[3:0]};
		end else if (f == FMT_HEX && c[3:0] >= 4'h1 && c[3:0] <= 4'h6
			&& (c[7:4] == 4'h4 || c[7:4] == 4'h6)) begin
			r = {1'b1, 4'(c[3:0] + 4'h9)};
		end
		return r;
	endfunction : pio_dec

	// Nibble to character
	function automatic logic [7:0] pio_enc(input logic [3:0] n, input logic leg);
		logic [7:0] r;
		r = leg ? {CH_LEG_HI, n} : (n < 4'hA ? CH_ZERO + {4'h0, n} : CH_HEX_OFS + {4'h0, n});
		return r;
	endfunction : pio_enc

	// ****************************************************************
	// State
	// ****************************************************************
	logic [NLINES-1:0] din_m_q, din_s_q;
	logic [8:0] sw_m_q, sw_s_q;
	logic [14:0] pw_q;
	logic [4:0] cfg_out_q, cfg_in_q, opol_q, ipol_q, forced_q, forced_d;
	logic [1:0] fmt_q;
	logic dual_q, lock_q, ext_q, err_q;
	logic [4:0] addr_q;
	logic [1:0] boot_q;
	logic [5:0] qsel_q;
	logic [6:0] idn_ptr_q;
	logic [7:0] idn_mem [0:IDN_LEN-1];
	logic [NLINES-1:0] out_q, out_d, pend_q, pend_d, act_q, act_d, snap_q;
	logic start_q, start_d;
	logic [5:0] stb_q;
	logic [2:0] so_idx_q, so_idx_d, si_idx_q;
	logic so_act_q, so_act_d, nib_q, nib_d, dig_q, dig_d;
	logic [7:0] acc_q, acc_d;
	logic [1:0] si_ch_q;
	pio_sin_t si_st_q;
	logic stb_fire, err_data;
	logic [31:0] rd_mux;
	pio_pulse_if pif ();

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire [3:0] cmd_op = WDATA[OP_LSB+3:OP_LSB];
	wire cmd_go = WDATA[GO_BIT];
	wire [2:0] cmd_byte = WDATA[BYTE_LSB+2:BYTE_LSB];
	wire [5:0] cmd_line = {cmd_byte, WDATA[BIT_LSB+2:BIT_LSB]};
	wire [5:0] cmd_chan = WDATA[5:0];
	wire byte_ok = 32'(cmd_byte) < NBYTES;
	wire chan_ok = 32'(cmd_chan) < NLINES;
	wire cmd_wr = WR && ADDR == OFS_CMD;
	wire cfg_sel = ADDR == OFS_PW || ADDR == OFS_CFG_OUT || ADDR == OFS_CFG_IN
		|| ADDR == OFS_OUT_POL || ADDR == OFS_IN_POL || ADDR == OFS_FORMAT
		|| ADDR == OFS_MODE || ADDR == OFS_BUS_ADDR || ADDR == OFS_IDN_PTR
		|| ADDR == OFS_IDN_DATA || (ADDR == OFS_CMD && cmd_op == OP_DEFAULT);
	wire lock_err = WR && cfg_sel && lock_q;
	wire cfg_wr = WR && !lock_q;
	wire pw_ok = WDATA[31:15] == '0 && WDATA[14:0] >= PW_MIN && WDATA[14:0] <= PW_MAX;
	wire idn_full = idn_ptr_q == IDN_END;
	wire idn_err = cfg_wr && ADDR == OFS_IDN_DATA && idn_full;
	wire pw_err = cfg_wr && ADDR == OFS_PW && !pw_ok;
	wire xf_wr = WR && ADDR == OFS_XFER && dual_q;
	wire ch_wr = (WR && ADDR == OFS_STR_OUT) || xf_wr;
	wire xf_err = WR && ADDR == OFS_XFER && !dual_q;
	wire clr_err = WR && ADDR == OFS_STATUS && WDATA[0];
	wire err_set = lock_err || idn_err || pw_err || xf_err || err_data;

	// Polarity and drive masks spread to lines
	wire [NLINES-1:0] opol_x, ipol_x, oe_x;
	for (genvar g = 0; g < NBYTES; g++) begin : g_spread
		assign opol_x[g*8 +: 8] = {8{opol_q[g]}};
		assign ipol_x[g*8 +: 8] = {8{ipol_q[g]}};
		assign oe_x[g*8 +: 8] = {8{cfg_out_q[g] | forced_q[g]}};
	end
	wire [NLINES-1:0] in_val = din_s_q ^ ipol_x;

	// ****************************************************************
	// Pin synchronisers and power-on address capture
	// ****************************************************************
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			din_m_q <= '0;
			din_s_q <= '0;
			sw_m_q <= '0;
			sw_s_q <= '0;
		end else begin
			din_m_q <= DIO_IN;
			din_s_q <= din_m_q;
			sw_m_q <= {EXT_ADDR_EN, ADDR_SW};
			sw_s_q <= sw_m_q;
		end
	end

	// ****************************************************************
	// Configuration, lock and address
	// ****************************************************************
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			pw_q <= PW_DEF;
			{cfg_out_q, cfg_in_q, opol_q, ipol_q} <= '0;
			fmt_q <= FMT_DEC;
			dual_q <= 1'b0;
			lock_q <= 1'b0;
			addr_q <= ADDR_DEF;
			ext_q <= 1'b0;
			boot_q <= '0;
			qsel_q <= '0;
			idn_ptr_q <= '0;
			err_q <= 1'b0;
		end else begin
			if (32'(boot_q) < BOOT_CYC) begin
				boot_q <= boot_q + 1'b1;
				// A switch setting above the top bus address keeps the default
				if (32'(boot_q) == BOOT_CYC - 1 && sw_s_q[8]
					&& sw_s_q[4:0] <= ADDR_MAX) begin
					addr_q <= sw_s_q[4:0];
					ext_q <= 1'b1;
				end
			end else if (cfg_wr && ADDR == OFS_BUS_ADDR && !ext_q
				&& WDATA[4:0] <= ADDR_MAX) begin
				addr_q <= WDATA[4:0];
			end
			if (cfg_wr && ADDR == OFS_PW && pw_ok) pw_q <= WDATA[14:0];
			if (cfg_wr && ADDR == OFS_CFG_OUT) cfg_out_q <= WDATA[4:0];
			if (cfg_wr && ADDR == OFS_CFG_IN) cfg_in_q <= WDATA[4:0];
			if (cfg_wr && ADDR == OFS_OUT_POL) opol_q <= WDATA[4:0];
			if (cfg_wr && ADDR == OFS_IN_POL) ipol_q <= WDATA[4:0];
			if (cfg_wr && ADDR == OFS_FORMAT && WDATA[1:0] != 2'h3) fmt_q <= WDATA[1:0];
			if (cfg_wr && ADDR == OFS_MODE) dual_q <= WDATA[0];
			if (WR && ADDR == OFS_LOCK) lock_q <= WDATA[0];
			if (WR && ADDR == OFS_QSEL) qsel_q <= WDATA[5:0];
			if (cfg_wr && ADDR == OFS_IDN_PTR) begin
				idn_ptr_q <= WDATA[6:0] > IDN_END ? IDN_END : WDATA[6:0];
			end else if (((cfg_wr && ADDR == OFS_IDN_DATA) || (RD && ADDR == OFS_IDN_DATA))
				&& !idn_full) begin
				idn_ptr_q <= idn_ptr_q + 1'b1;
			end
			if (cmd_wr && cfg_wr && cmd_op == OP_DEFAULT) begin
				pw_q <= PW_DEF;
				{cfg_out_q, cfg_in_q, opol_q, ipol_q} <= '0;
				fmt_q <= FMT_DEC;
				dual_q <= 1'b0;
				idn_ptr_q <= '0;
			end
			err_q <= err_set || (err_q && !clr_err);
		end
	end

	// Identity characters; no reset needed for plain storage
	always_ff @(posedge REF_CLK) begin
		if (cfg_wr && ADDR == OFS_IDN_DATA && !idn_full) idn_mem[idn_ptr_q] <= WDATA[7:0];
	end

	// ****************************************************************
	// Output commands and string output
	// ****************************************************************
	wire [3:0] so_first = pio_next(cfg_out_q, 4'h0);
	wire [2:0] so_cur = so_act_q ? so_idx_q : so_first[2:0];
	wire [3:0] so_nxt = pio_next(cfg_out_q, {1'b0, so_cur} + 4'h1);
	wire [4:0] dv = pio_dec(WDATA[7:0], fmt_q);
	wire [11:0] acc10 = {4'h0, acc_q} * 12'h00A + {8'h00, dv[3:0]};
	wire is_sep = WDATA[7:0] == CH_COMMA || WDATA[END_BIT];

	always_comb begin
		out_d = out_q;
		forced_d = forced_q;
		pend_d = pend_q;
		act_d = act_q;
		start_d = 1'b0;
		stb_fire = 1'b0;
		err_data = 1'b0;
		so_idx_d = so_idx_q;
		so_act_d = so_act_q;
		acc_d = acc_q;
		nib_d = nib_q;
		dig_d = dig_q;
		if (cmd_wr) begin
			case (cmd_op)
				OP_BIT_SET, OP_BIT_CLR: begin
					if (byte_ok) out_d[cmd_line] = cmd_op == OP_BIT_SET;
					else err_data = 1'b1;
				end
				OP_BYTE_CLR: begin
					if (byte_ok) out_d[{cmd_byte, 3'h0} +: 8] = 8'h00;
					else err_data = 1'b1;
				end
				// collect lines by bit or channel
				OP_PULSE_BIT: begin
					if (byte_ok) pend_d[cmd_line] = 1'b1;
					else err_data = 1'b1;
				end
				OP_PULSE_CHAN: begin
					if (chan_ok) pend_d[cmd_chan] = 1'b1;
					else err_data = 1'b1;
				end
				OP_BYTE_WR: begin
					if (byte_ok) begin
						out_d[{cmd_byte, 3'h0} +: 8] = WDATA[7:0];
						forced_d[cmd_byte] = 1'b1;
					end else begin
						err_data = 1'b1;
					end
				end
				OP_STROBE: stb_fire = 1'b1;
				OP_DEFAULT: forced_d = lock_q ? forced_q : '0;
				default: err_data = 1'b1;
			endcase
			if ((cmd_op == OP_PULSE_BIT || cmd_op == OP_PULSE_CHAN) && cmd_go) begin
				act_d = pend_d;
				pend_d = '0;
				start_d = 1'b1;
			end
		end
		if (ch_wr) begin
			if (so_first[3]) begin
				err_data = 1'b1;
			end else if (fmt_q == FMT_DEC) begin
				if (dv[4]) begin
					acc_d = acc10[7:0];
					dig_d = 1'b1;
					err_data = acc10 > 12'h0FF;
				end
				if (is_sep && (dig_q || dv[4])) begin
					out_d[{so_cur, 3'h0} +: 8] = acc_d;
					acc_d = 8'h00;
					dig_d = 1'b0;
					so_idx_d = so_nxt[2:0];
					so_act_d = !so_nxt[3];
					stb_fire = so_nxt[3];
				end else if (!dv[4] && !is_sep) begin
					err_data = 1'b1;
				end
			end else if (dv[4]) begin
				nib_d = !nib_q;
				acc_d = {acc_q[3:0], dv[3:0]};
				if (nib_q) begin
					out_d[{so_cur, 3'h0} +: 8] = acc_d;
					// Clear so a later decimal string starts from zero
					acc_d = 8'h00;
					so_idx_d = so_nxt[2:0];
					so_act_d = !so_nxt[3];
					stb_fire = so_nxt[3];
				end
			end else if (WDATA[7:0] != CH_COMMA) begin
				err_data = 1'b1;
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			{out_q, pend_q, act_q} <= '0;
			forced_q <= '0;
			start_q <= 1'b0;
			stb_q <= '0;
			so_idx_q <= '0;
			{so_act_q, nib_q, dig_q} <= '0;
			acc_q <= '0;
		end else begin
			{out_q, pend_q, act_q} <= {out_d, pend_d, act_d};
			forced_q <= forced_d;
			start_q <= start_d;
			stb_q <= stb_fire ? 6'(STB_CYC) : (stb_q != '0 ? stb_q - 1'b1 : stb_q);
			so_idx_q <= so_idx_d;
			{so_act_q, nib_q, dig_q} <= {so_act_d, nib_d, dig_d};
			acc_q <= acc_d;
		end
	end

	// ****************************************************************
	// Pulse timer and pin drive
	// ****************************************************************
	assign pif.start = start_q;
	assign pif.width_ms = pw_q;
	pio_pulse_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
		.clk(REF_CLK),
		.rst(RESET),
		.pif(pif)
	);

	// pulse overlays latch, latch returns after
	wire [NLINES-1:0] drive = (out_q | (act_q & {NLINES{pif.busy}})) ^ opol_x;

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			DIO_OUT <= '0;
			DIO_OE <= '0;
			DATA_STROBE <= 1'b0;
			BUS_ADDR <= ADDR_DEF;
			CMD_ERROR <= 1'b0;
		end else begin
			DIO_OUT <= drive;
			DIO_OE <= oe_x;
			DATA_STROBE <= stb_fire || stb_q > 6'h01;
			BUS_ADDR <= addr_q;
			CMD_ERROR <= err_q;
		end
	end

	// ****************************************************************
	// String input walk
	// ****************************************************************
	wire si_rd = RD && (ADDR == OFS_STR_IN || (ADDR == OFS_XFER && dual_q));
	wire [3:0] si_first = pio_next(cfg_in_q, 4'h0);
	wire [2:0] si_cur = si_st_q == SI_RUN ? si_idx_q : si_first[2:0];
	wire [NLINES-1:0] si_src = si_st_q == SI_RUN ? snap_q : in_val;
	wire [7:0] si_byte = si_src[{si_cur, 3'h0} +: 8];
	wire [3:0] si_nxt = pio_next(cfg_in_q, {1'b0, si_cur} + 4'h1);
	wire si_lastc = si_ch_q == (fmt_q == FMT_DEC ? 2'h2 : 2'h1);
	wire si_final = si_lastc && si_nxt[3];
	wire [7:0] d_h = si_byte / 8'h64;
	wire [7:0] d_t = (si_byte / 8'h0A) % 8'h0A;
	wire [7:0] d_o = si_byte % 8'h0A;
	wire [7:0] dec_c = CH_ZERO + (si_ch_q == 2'h0 ? d_h : (si_ch_q == 2'h1 ? d_t : d_o));
	wire [7:0] hex_c = pio_enc(si_ch_q == 2'h0 ? si_byte[7:4] : si_byte[3:0], fmt_q == FMT_LEG);
	wire [8:0] si_char = si_first[3] ? 9'h100 : {si_final, fmt_q == FMT_DEC ? dec_c : hex_c};

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			si_st_q <= SI_IDLE;
			si_idx_q <= '0;
			si_ch_q <= '0;
			snap_q <= '0;
		end else if (si_rd && !si_first[3]) begin
			case (si_st_q)
				SI_IDLE: snap_q <= in_val;
				SI_RUN: snap_q <= snap_q;
				default: snap_q <= in_val;
			endcase
			si_st_q <= si_final ? SI_IDLE : SI_RUN;
			si_idx_q <= si_lastc ? si_nxt[2:0] : si_cur;
			si_ch_q <= si_lastc ? 2'h0 : si_ch_q + 1'b1;
		end
	end

	// ****************************************************************
	// Read-back
	// ****************************************************************
	always_comb begin
		case (ADDR)
			OFS_PW: rd_mux = {17'h0, pw_q};
			OFS_CFG_OUT: rd_mux = {27'h0, cfg_out_q};
			OFS_CFG_IN: rd_mux = {27'h0, cfg_in_q};
			OFS_OUT_POL: rd_mux = {27'h0, opol_q};
			OFS_IN_POL: rd_mux = {27'h0, ipol_q};
			OFS_FORMAT: rd_mux = {30'h0, fmt_q};
			OFS_MODE: rd_mux = {31'h0, dual_q};
			OFS_LOCK: rd_mux = {31'h0, lock_q};
			OFS_BUS_ADDR: rd_mux = {26'h0, ext_q, addr_q};
			OFS_QSEL: rd_mux = {26'h0, qsel_q};
			OFS_BIT_Q: rd_mux = {31'h0, 32'(qsel_q) < NLINES && in_val[qsel_q]};
			OFS_BYTE_Q: rd_mux = 32'(qsel_q[5:3]) < NBYTES
				? {24'h0, in_val[{qsel_q[5:3], 3'h0} +: 8]} : 32'h0;
			OFS_STR_IN: rd_mux = {23'h0, si_char};
			OFS_XFER: rd_mux = dual_q ? {23'h0, si_char} : 32'h0;
			OFS_IDN_PTR: rd_mux = {25'h0, idn_ptr_q};
			OFS_IDN_DATA: rd_mux = idn_full ? 32'h0 : {24'h0, idn_mem[idn_ptr_q]};
			OFS_STATUS: rd_mux = {27'h0, so_act_q, si_st_q == SI_RUN, pif.busy, lock_q, err_q};
			OFS_OUT_Q: rd_mux = {27'h0, forced_q};
			default: rd_mux = 32'h0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) RDATA <= '0;
		else RDATA <= RD ? rd_mux : 32'h0;
	end
endmodule : pio_cmd_top

// *** rtl/pio_pkg.sv ***
// ****************************************************************
// Shared constants for the parallel I/O command handler
// ****************************************************************
package pio_pkg;
	localparam int NBYTES = 5;
	localparam int NLINES = 40;
	// Clock rate and derived cycle counts
	localparam int CLK_HZ = 10_000_000;
	localparam int PULSE_UNIT_MS = 1;
	localparam int CYC_PER_MS = CLK_HZ / 1000 * PULSE_UNIT_MS;
	localparam int STB_TIME_NS = 5000;
	localparam int STB_CYC = (STB_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int BOOT_CYC = 3;
	// Pulse width limits and default, in milliseconds
	localparam logic [14:0] PW_MIN = 15'h000A;
	localparam logic [14:0] PW_MAX = 15'h7530;
	localparam logic [14:0] PW_DEF = 15'h0032;
	// Register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_PW = 8'h04;
	localparam logic [7:0] OFS_CFG_OUT = 8'h08;
	localparam logic [7:0] OFS_CFG_IN = 8'h0C;
	localparam logic [7:0] OFS_OUT_POL = 8'h10;
	localparam logic [7:0] OFS_IN_POL = 8'h14;
	localparam logic [7:0] OFS_FORMAT = 8'h18;
	localparam logic [7:0] OFS_MODE = 8'h1C;
	localparam logic [7:0] OFS_LOCK = 8'h20;
	localparam logic [7:0] OFS_BUS_ADDR = 8'h24;
	localparam logic [7:0] OFS_QSEL = 8'h28;
	localparam logic [7:0] OFS_BIT_Q = 8'h2C;
	localparam logic [7:0] OFS_BYTE_Q = 8'h30;
	localparam logic [7:0] OFS_STR_OUT = 8'h34;
	localparam logic [7:0] OFS_STR_IN = 8'h38;
	localparam logic [7:0] OFS_XFER = 8'h3C;
	localparam logic [7:0] OFS_IDN_PTR = 8'h40;
	localparam logic [7:0] OFS_IDN_DATA = 8'h44;
	localparam logic [7:0] OFS_STATUS = 8'h48;
	localparam logic [7:0] OFS_OUT_Q = 8'h4C;
	// Command word fields
	localparam int OP_LSB = 24;
	localparam int GO_BIT = 20;
	localparam int BYTE_LSB = 16;
	localparam int BIT_LSB = 8;
	localparam int END_BIT = 8;
	// Command opcodes
	localparam logic [3:0] OP_BIT_SET = 4'h1;
	localparam logic [3:0] OP_BIT_CLR = 4'h2;
	localparam logic [3:0] OP_BYTE_CLR = 4'h3;
	localparam logic [3:0] OP_PULSE_BIT = 4'h4;
	localparam logic [3:0] OP_PULSE_CHAN = 4'h5;
	localparam logic [3:0] OP_BYTE_WR = 4'h6;
	localparam logic [3:0] OP_STROBE = 4'h7;
	localparam logic [3:0] OP_DEFAULT = 4'h8;
	// String formats
	localparam logic [1:0] FMT_DEC = 2'h0;
	localparam logic [1:0] FMT_HEX = 2'h1;
	localparam logic [1:0] FMT_LEG = 2'h2;
	// Characters
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_HEX_OFS = 8'h37;
	localparam logic [3:0] CH_LEG_HI = 4'h3;
	// Bus address limits and identity store
	localparam logic [4:0] ADDR_MAX = 5'h1E;
	localparam logic [4:0] ADDR_DEF = 5'h01;
	localparam int IDN_LEN = 72;
	localparam logic [6:0] IDN_END = 7'h48;
	// String input walk state
	typedef enum logic {SI_IDLE = 1'b0, SI_RUN = 1'b1} pio_sin_t;
endpackage : pio_pkg

// *** rtl/pio_pulse_if.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Link between command logic and pulse timer
// ****************************************************************
interface pio_pulse_if;
	logic start;
	logic [14:0] width_ms;
	logic busy;
	modport ctl (output start, output width_ms, input busy);
	modport tmr (input start, input width_ms, output busy);
endinterface : pio_pulse_if

// *** rtl/pio_pulse_timer.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Millisecond pulse timer
// ****************************************************************
module pio_pulse_timer #(
	parameter int CYC_PER_MS = pio_pkg::CYC_PER_MS
) (
	input wire logic clk, // Block clock
	input wire logic rst, // Async reset, high
	pio_pulse_if.tmr pif // Start and busy
);
	import pio_pkg::*;
	localparam int PB = $clog2(CYC_PER_MS + 1);
	localparam logic [PB-1:0] PRE_LAST = PB'(CYC_PER_MS - 1);

	logic [PB-1:0] pre_q;
	logic [14:0] ms_q;
	logic busy_q;
	wire tick = busy_q && (pre_q == PRE_LAST);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_q <= '0;
			ms_q <= '0;
			busy_q <= 1'b0;
		end else if (pif.start) begin
			// Restart wins so a new command retimes the whole pulse
			pre_q <= '0;
			ms_q <= pif.width_ms;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			pre_q <= tick ? '0 : pre_q + 1'b1;
			ms_q <= tick ? ms_q - 1'b1 : ms_q;
			busy_q <= !(tick && ms_q == 15'h0001);
		end
	end

	assign pif.busy = busy_q;
endmodule : pio_pulse_timer

// *** verif/pio_cmd_chk.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the command handler
// ****************************************************************
module pio_cmd_chk #(
	parameter int CYC_PER_MS = pio_pkg::CYC_PER_MS
) (
	input wire logic REF_CLK, // Clock
	input wire logic RESET, // Async reset, high
	input wire logic [7:0] ADDR, // Register address
	input wire logic [31:0] WDATA, // Write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	input wire logic [31:0] RDATA, // Read data
	input wire logic [pio_pkg::NLINES-1:0] DIO_OE, // Drive enables
	input wire logic DATA_STROBE, // Data strobe
	input wire logic [4:0] BUS_ADDR, // Bus address
	input wire logic CMD_ERROR // Error flag
);
	import pio_pkg::*;
	logic [7:0] stb_cnt_q;
	// Strobe length so far; zero between pulses
	wire [7:0] stb_cnt_d = DATA_STROBE ? stb_cnt_q + 8'h01 : 8'h00;
	wire cmd_wr = WR && ADDR == OFS_CMD;
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			stb_cnt_q <= 8'h00;
		end else begin
			stb_cnt_q <= stb_cnt_d;
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	rd_idle_a:
		assert property (!$past(RD) |-> RDATA == 32'h0) else $error("stray read data");
	strobe_len_a:
		assert property ($fell(DATA_STROBE) |-> stb_cnt_q == 8'(STB_CYC)) else $error("strobe len");
	man_strobe_a:
		assert property (cmd_wr && WDATA[27:24] == OP_STROBE |=> DATA_STROBE)
			else $error("no manual strobe");
	byte_drive_a:
		assert property (cmd_wr && WDATA[27:24] == OP_BYTE_WR && WDATA[18:16] < 3'h5
			|-> ##2 DIO_OE[$past(WDATA[18:16], 2) * 8 +: 8] == 8'hFF) else $error("byte undriven");
	err_hold_a:
		assert property ($fell(CMD_ERROR) |-> $past(WR && ADDR == OFS_STATUS && WDATA[0], 2))
			else $error("error flag lost");
	pw_range_a:
		assert property (WR && ADDR == OFS_PW && (WDATA[14:0] < PW_MIN || WDATA[14:0] > PW_MAX)
			|-> ##2 CMD_ERROR) else $error("width not refused");
	addr_range_a:
		assert property (BUS_ADDR <= ADDR_MAX) else $error("bus address out of range");
	oe_cause_a:
		assert property ($changed(DIO_OE) |-> $past(WR, 2)) else $error("drive change uncaused");
	cover property ($rose(DATA_STROBE));
	cover property ($rose(CMD_ERROR));
	cover property (RD && ADDR == OFS_STR_IN);
endmodule : pio_cmd_chk

// *** verif/pio_dev_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Far-side parallel device
// ****************************************************************
module pio_dev_model (
	input wire logic [39:0] dout, // Pin levels from the block
	input wire logic [39:0] doe, // Pin drive enables
	input wire logic stb, // Data strobe
	input wire logic [39:0] dev_val, // Levels this device drives
	output logic [39:0] din, // Resolved pins
	output int nstb, // Strobes seen
	output logic [39:0] word // Word latched by strobe
);
	// Driven pins show the block, the rest this device
	assign din = (doe & dout) | (~doe & dev_val);
	logic armed;
	initial nstb = 0;
	initial armed = 1'b0;
	// Arm on a real rise so the drop from unknown at reset is not counted
	always @(posedge stb) armed = 1'b1;
	// Latch at strobe end so the bytes have surely settled
	always @(negedge stb) begin
		if (armed) begin
			armed = 1'b0;
			nstb = nstb + 1;
			word = dout;
		end
	end
endmodule : pio_dev_model

// *** verif/tb_pio_cmd_top.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Bench for the command handler
// ****************************************************************
module tb_pio_cmd_top;
	import pio_pkg::*;
	logic clk, rst, wr, rd, stb, err, ext;
	logic [7:0] adr;
	logic [31:0] wd, rdat, d;
	logic [39:0] din, dout, doe, dv, word;
	logic [4:0] badr;
	int miscompares = 0, compares = 0, nstb, n;
	// Ten cycles a millisecond keeps pulses short
	pio_cmd_top #(.CYC_PER_MS(10)) pio_cmd_top_i (.REF_CLK(clk), .RESET(rst), .ADDR(adr),
		.WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdat), .DIO_IN(din), .DIO_OUT(dout),
		.DIO_OE(doe), .DATA_STROBE(stb), .ADDR_SW(8'h07), .EXT_ADDR_EN(ext),
		.BUS_ADDR(badr), .CMD_ERROR(err));
	pio_dev_model pio_dev_model_i (.dout(dout), .doe(doe), .stb(stb), .dev_val(dv),
		.din(din), .nstb(nstb), .word(word));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wrr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		adr <= a;
		wd <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrr
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		adr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdat;
	endtask : rdr
	task automatic cmd(input logic [3:0] op, input logic [2:0] b, input logic [7:0] v,
		input logic go);
		wrr(OFS_CMD, {4'h0, op, 3'h0, go, 1'b0, b, 5'h0, v[2:0], v});
	endtask : cmd
	task automatic t_str(input logic [7:0] a, input logic [1:0] f, input string s,
		input logic [15:0] e);
		n = nstb;
		wrr(OFS_FORMAT, {30'h0, f});
		for (int i = 0; i < s.len(); i++) begin
			wrr(a, {23'h0, f == FMT_DEC && i == s.len() - 1, s[i]});
		end
		cyc(60);
		chk(nstb - n, 1);
		chk(word[15:0], e);
		chk(dout[39:32], 8'h27);
	endtask : t_str
	task automatic results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		results();
	end
	task automatic t_boot;
		chk(badr, 5'h07);
		rdr(OFS_PW);
		chk(d, 32'h32);
	endtask : t_boot
	// Byte write, then bit set (bit 1) and clear (bit 7)
	task automatic t_bits;
		cmd(OP_BYTE_WR, 3'h4, 8'hA5, 1'b0);
		cyc(2);
		chk(dout[39:32], 8'hA5);
		chk(doe[39:32], 8'hFF);
		cmd(OP_BIT_SET, 3'h4, 8'h01, 1'b0);
		cmd(OP_BIT_CLR, 3'h4, 8'h07, 1'b0);
		cyc(2);
		chk(dout[39:32], 8'h27);
	endtask : t_bits
	// Strings to bytes 0 and 1 in every format, then a manual strobe
	task automatic t_out;
		wrr(OFS_CFG_OUT, 32'h3);
		t_str(OFS_STR_OUT, FMT_HEX, "12AB", 16'hAB12);
		t_str(OFS_STR_OUT, FMT_DEC, "18,255", 16'hFF12);
		t_str(OFS_STR_OUT, FMT_LEG, ":?01", 16'h01AF);
		wrr(OFS_MODE, 32'h1);
		t_str(OFS_XFER, FMT_HEX, "3C5A", 16'h5A3C);
		n = nstb;
		cmd(OP_STROBE, 3'h0, 8'h00, 1'b0);
		cyc(60);
		chk(nstb - n, 1);
	endtask : t_out
	// Pulse two lines of byte 4 together, minimum width
	task automatic t_pulse;
		wrr(OFS_PW, 32'hA);
		wrr(OFS_PW, 32'h5);
		cyc(2);
		chk(err, 1'b1);
		cmd(OP_PULSE_BIT, 3'h4, 8'h03, 1'b0);
		cmd(OP_PULSE_CHAN, 3'h0, 8'h24, 1'b1);
		cyc(95);
		chk(dout[39:32], 8'h3F);
		cyc(15);
		chk(dout[39:32], 8'h27);
		cmd(OP_BYTE_CLR, 3'h4, 8'h00, 1'b0);
		cyc(2);
		chk(dout[39:32], 8'h00);
	endtask : t_pulse
	// Inputs: byte 3 holds 0x5C
	task automatic t_inputs;
		wrr(OFS_QSEL, 32'h1A);
		rdr(OFS_BIT_Q);
		chk(d, 32'h1);
		wrr(OFS_QSEL, 32'h18);
		rdr(OFS_BYTE_Q);
		chk(d, 32'h5C);
		wrr(OFS_CFG_IN, 32'h8);
		rdr(OFS_STR_IN);
		chk(d, 32'h35);
		rdr(OFS_STR_IN);
		chk(d, 32'h143);
		@(posedge clk);
		dv <= 40'hFF7EFFFFFF;
		cyc(4);
		rdr(OFS_XFER);
		chk(d, 32'h37);
		rdr(OFS_FORMAT);
		chk(d, 32'h1);
		// Inverting byte 3 reads back and flips the byte query
		wrr(OFS_IN_POL, 32'h8);
		rdr(OFS_IN_POL);
		chk(d, 32'h8);
		rdr(OFS_BYTE_Q);
		chk(d, 32'h81);
	endtask : t_inputs
	// Lock refuses a width change and flags it
	task automatic t_lock;
		wrr(OFS_STATUS, 32'h1);
		wrr(OFS_LOCK, 32'h1);
		wrr(OFS_PW, 32'hC8);
		rdr(OFS_PW);
		chk(d, 32'hA);
		chk(err, 1'b1);
		wrr(OFS_LOCK, 32'h0);
		cmd(OP_DEFAULT, 3'h0, 8'h00, 1'b0);
		rdr(OFS_PW);
		chk(d, 32'h32);
		rdr(8'hFC);
		chk(d, 32'h0);
	endtask : t_lock
	// Reset again with the switch disabled: default address, software may set it
	task automatic t_reset2;
		@(posedge clk);
		ext <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		cyc(5);
		chk(badr, 5'h01);
		wrr(OFS_BUS_ADDR, 32'h0C);
		cyc(2);
		chk(badr, 5'h0C);
	endtask : t_reset2
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		ext = 1'b1;
		adr = 8'h00;
		wd = 32'h0;
		dv = 40'hFF5CFFFFFF;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		cyc(5);
		t_boot();
		t_bits();
		t_out();
		t_pulse();
		t_inputs();
		t_lock();
		t_reset2();
		results();
	end
endmodule : tb_pio_cmd_top
bind pio_cmd_top pio_cmd_chk #(.CYC_PER_MS(CYC_PER_MS)) pio_cmd_chk_i (.REF_CLK(REF_CLK),
	.RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.DIO_OE(DIO_OE), .DATA_STROBE(DATA_STROBE), .BUS_ADDR(BUS_ADDR), .CMD_ERROR(CMD_ERROR));
